// File: dv/ctl_bit_exec_tb.sv
// Self-checking bench for the control and bit-bus executor
`default_nettype none
module ctl_bit_exec_tb
	import ctl_bit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LC = 20;
	// ----------------------------------------------------------------
	// Design and far side
	// ----------------------------------------------------------------
	logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h4D1E, r;
	logic        pready, pslverr, instrValid = 1'b0, instrReady, bitIn, bitOut, bitWrite;
	logic [15:0] instrWord = 16'h0, wr12 = 16'h0, intPc, memRdata, pc;
	logic        idleSig, offDec, onDec, restartDec, errTrap, intTake, memAck;
	logic        extIntReq = 1'b0, restartReq = 1'b0, loadReq = 1'b0;
	logic [3:0]  extIntLevel = 4'h0, intLevel;
	logic [11:0] bitAddr, ea;
	logic [2:0]  ackWait = 3'h0;
	mem_req_t    mem;
	logic [39:0] notes [$];
	logic [15:0] ctlOps [4] = '{OP_IDLE, OP_CLOCK_OFF, OP_CLOCK_ON, OP_LOAD_RESTART};
	int          mismatches = 0, n_checks = 0;
	always #4 clk = ~clk;
	ctl_bit_exec #(.LINE_CYCLES(LC)) DUT (.clk(clk), .resetn(resetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instrValid(instrValid), .instrWord(instrWord), .wr12(wr12),
		.instrReady(instrReady), .idleSig(idleSig), .offDec(offDec), .onDec(onDec),
		.restartDec(restartDec), .errTrap(errTrap), .extIntReq(extIntReq),
		.extIntLevel(extIntLevel), .restartReq(restartReq), .loadReq(loadReq),
		.intTake(intTake), .intLevel(intLevel), .intPc(intPc), .bitIn(bitIn),
		.bitAddr(bitAddr), .bitOut(bitOut), .bitWrite(bitWrite), .memAck(memAck),
		.memRdata(memRdata), .mem(mem));
	ctl_bit_far far (.clk(clk), .resetn(resetn), .ackWait(ackWait), .vecWp(16'h0040),
		.vecPc(16'h1234), .offDec(offDec), .onDec(onDec), .restartDec(restartDec),
		.bitAddr(bitAddr), .bitOut(bitOut), .bitWrite(bitWrite), .bitIn(bitIn),
		.mem(mem), .memAck(memAck), .memRdata(memRdata));
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic check(input string what, input logic [39:0] e, input logic [39:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic note(input logic [3:0] k, input logic [35:0] v);
		notes.push_back({k, v});
	endtask : note
	task automatic got(input logic [3:0] k, input logic [35:0] v);
		check("event", (notes.size() > 0) ? notes.pop_front() : 40'hF0, {k, v});
	endtask : got
	always @(posedge clk) begin
		if (pready) got(4'h1, {3'h0, pslverr, pwrite ? 32'h0 : prdata});
		if (bitWrite) got(4'h2, {23'h0, bitAddr, bitOut});
		if (errTrap) got(4'h3, 36'h0);
		if (offDec) got(4'h4, 36'h0);
		if (onDec) got(4'h5, 36'h0);
		if (restartDec) got(4'h6, 36'h0);
		if (intTake) got(4'h7, {16'h0, intLevel, intPc});
	end
	task automatic waitHigh(input logic onInt);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((onInt ? intTake : instrReady) !== 1'b1 && n < 200);
		if (n >= 200) begin
			mismatches++;
			final_report();
		end
	endtask : waitHigh
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		waitPready();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic waitPready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			final_report();
		end
	endtask : waitPready
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
		note(4'h1, {3'h0, e, d});
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		note(4'h1, 36'h0);
		apb(1'b1, a, d);
	endtask : wr
	task automatic issue(input logic [15:0] w);
		@(posedge clk);
		instrValid <= 1'b1;
		instrWord <= w;
		waitHigh(1'b0);
		instrValid <= 1'b0;
		pc = pc + 16'h2;
	endtask : issue
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rd(CTRL_OFS, 32'h0, 1'b0);
		rd(8'h14, 32'h0, 1'b1);
		rd(STAT_OFS, 32'h1, 1'b0);
		wr(SR_OFS, 32'hF);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			wr12 <= r[31:16];
			ea = r[28:17] + {{4{r[7]}}, r[7:0]};
			note(4'h2, {23'h0, ea, i[0]});
			issue({i[0] ? OP_SET_ONE : OP_SET_ZERO, r[7:0]});
		end
		repeat (2) @(posedge clk);
		check("bit bus", 40'h1, far.bits[ea]);
		rd(SR_OFS, 32'hF, 1'b0);
		for (int v = 0; v < 2; v++) begin
			far.bits[12'h123] = v[0];
			wr12 <= 16'h0246;
			issue({OP_TEST_BIT, 8'h00});
			waitHigh(1'b0);
			rd(SR_OFS, 32'hF | (v << 13), 1'b0);
		end
		wr(CTRL_OFS, 32'h1);
		wr(SR_OFS, 32'h10F);
		foreach (ctlOps[j]) begin
			note(4'h3, 36'h0);
			issue(ctlOps[j]);
		end
		wr12 <= 16'h1BFE;
		note(4'h3, 36'h0);
		issue({OP_SET_ONE, 8'h01});
		note(4'h2, {23'h0, 12'hDFF, 1'b1});
		issue({OP_SET_ONE, 8'h00});
		wr(CTRL_OFS, 32'h0);
		wr(SR_OFS, 32'hF);
		wr(PC_OFS, 32'h200);
		pc = 16'h0200;
		note(4'h5, 36'h0);
		issue(OP_CLOCK_ON);
		note(4'h7, {16'h0, CLOCK_LEVEL, pc});
		waitHigh(1'b1);
		repeat (2) @(posedge clk);
		rd(SR_OFS, 32'h4, 1'b0);
		repeat (LC + 2) @(posedge clk);
		rd(STAT_OFS, 32'hD, 1'b0);
		note(4'h4, 36'h0);
		issue(OP_CLOCK_OFF);
		rd(STAT_OFS, 32'h1, 1'b0);
		rd(SR_OFS, 32'h4, 1'b0);
		wr(SR_OFS, 32'hF);
		repeat (2 * LC + 4) @(posedge clk);
		issue(OP_IDLE);
		repeat (2) @(posedge clk);
		check("idle", 40'h1, idleSig);
		rd(STAT_OFS, 32'h22, 1'b0);
		note(4'h7, {16'h0, 4'h3, pc});
		extIntLevel <= 4'h3;
		extIntReq <= 1'b1;
		waitHigh(1'b1);
		extIntReq <= 1'b0;
		@(posedge clk);
		check("idle", 40'h0, idleSig);
		issue(OP_IDLE);
		repeat (3) @(posedge clk);
		check("idle", 40'h1, idleSig);
		restartReq <= 1'b1;
		waitHigh(1'b0);
		restartReq <= 1'b0;
		check("idle", 40'h0, idleSig);
		issue(OP_IDLE);
		repeat (3) @(posedge clk);
		check("idle", 40'h1, idleSig);
		loadReq <= 1'b1;
		waitHigh(1'b0);
		loadReq <= 1'b0;
		check("idle", 40'h0, idleSig);
		wr(CTRL_OFS, 32'h2);
		wr(WP_OFS, 32'h80);
		wr(PC_OFS, 32'h300);
		wr(SR_OFS, 32'h218F);
		ackWait <= 3'h3;
		note(4'h6, 36'h0);
		issue(OP_LOAD_RESTART);
		waitHigh(1'b0);
		rd(WP_OFS, 32'h40, 1'b0);
		rd(PC_OFS, 32'h1234, 1'b0);
		rd(SR_OFS, 32'h2000, 1'b0);
		check("save13", 40'h80, far.ram[7'h2D]);
		check("save14", 40'h302, far.ram[7'h2E]);
		check("save15", 40'h218F, far.ram[7'h2F]);
		wr(CTRL_OFS, 32'h4);
		note(4'h5, 36'h0);
		issue(OP_CLOCK_ON);
		repeat (LC + 4) @(posedge clk);
		rd(STAT_OFS, 32'h1, 1'b0);
		repeat (4) @(posedge clk);
		check("decodes", 40'h4, 40'(far.nDec));
		check("queue", 40'h0, 40'(notes.size()));
		final_report();
	end
endmodule : ctl_bit_exec_tb
`default_nettype wire

// File: dv/ctl_bit_far.sv
// Far-side model: decode watcher, bit-addressed bus and context memory
`default_nettype none
module ctl_bit_far
	import ctl_bit_pkg::*;
(
	// Clock, reset, pacing and vector values
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [2:0]  ackWait,
	input  wire logic [15:0] vecWp,
	input  wire logic [15:0] vecPc,
	// Decode signals
	input  wire logic        offDec,
	input  wire logic        onDec,
	input  wire logic        restartDec,
	// Bit bus
	input  wire logic [11:0] bitAddr,
	input  wire logic        bitOut,
	input  wire logic        bitWrite,
	output logic             bitIn,
	// Memory port
	input  wire mem_req_t    mem,
	output logic             memAck,
	output logic      [15:0] memRdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4095:0] bits = '0;
	logic [15:0]   ram [128];
	logic [2:0]    waitCnt;
	int            nDec = 0;
	assign bitIn = bits[bitAddr];
	always @(posedge clk) begin
		if (bitWrite)
			bits[bitAddr] <= bitOut;
		if (offDec || onDec || restartDec)
			nDec <= nDec + 1;
	end
	// Ack after ackWait cycles; read data scrambles once released
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			memAck <= 1'b0;
			waitCnt <= 3'h0;
			memRdata <= 16'h5A5A;
		end else if (memAck || !mem.req) begin
			memAck <= 1'b0;
			waitCnt <= 3'h0;
			memRdata <= ~memRdata;
		end else if (waitCnt != ackWait) begin
			waitCnt <= waitCnt + 3'h1;
		end else begin
			memAck <= 1'b1;
			if (mem.we)
				ram[mem.addr[7:1]] <= mem.wdata;
			memRdata <= (mem.addr == VEC_WP_ADDR) ? vecWp :
				(mem.addr == VEC_PC_ADDR) ? vecPc : ram[mem.addr[7:1]];
		end
	end
endmodule : ctl_bit_far
`default_nettype wire

// File: rtl/ctl_bit_exec.sv
// Control and single-bit bus instruction executor with APB register access
`default_nettype none
module ctl_bit_exec
	import ctl_bit_pkg::*;
#(
	parameter int LINE_CYCLES = LINE_CYCLES_DEF
) (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Instruction issue
	input  wire logic        instrValid,
	input  wire logic [15:0] instrWord,
	input  wire logic [15:0] wr12,
	output logic             instrReady,
	// Decode signals and traps
	output logic             idleSig,
	output logic             offDec,
	output logic             onDec,
	output logic             restartDec,
	output logic             errTrap,
	// Interrupts
	input  wire logic        extIntReq,
	input  wire logic [3:0]  extIntLevel,
	input  wire logic        restartReq,
	input  wire logic        loadReq,
	output logic             intTake,
	output logic      [3:0]  intLevel,
	output logic      [15:0] intPc,
	// Bit-addressed bus
	input  wire logic        bitIn,
	output logic      [11:0] bitAddr,
	output logic             bitOut,
	output logic             bitWrite,
	// Memory port for context switch
	input  wire logic        memAck,
	input  wire logic [15:0] memRdata,
	output mem_req_t         mem
);
	localparam int CNT_W = $clog2(LINE_CYCLES);

	typedef struct packed {
		exec_state_t fsm;
		ctrl_t       ctrl;
		logic [15:0] wp;
		logic [15:0] pc;
		logic [15:0] sr;
		logic [15:0] oldWp;
		logic [15:0] oldPc;
		logic [15:0] oldSr;
		logic        lineClkOn;
		logic        clkPend;
		logic [CNT_W-1:0] lineCnt;
		logic [1:0]  testCnt;
		logic [1:0]  bitInSync;
		logic [1:0]  restartSync;
		logic [1:0]  loadSync;
		logic [1:0]  extReqSync;
		logic [3:0]  extLvl1;
		logic [3:0]  extLvl2;
		logic        instrReady;
		logic        idleSig;
		logic        offDec;
		logic        onDec;
		logic        restartDec;
		logic        errTrap;
		logic        intTake;
		logic [3:0]  intLevel;
		logic [15:0] intPc;
		logic [11:0] bitAddr;
		logic        bitOut;
		logic        bitWrite;
		mem_req_t    mem;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	logic        accept;
	logic        privOn;
	logic        ctlOp;
	logic [11:0] effAddr;
	logic        bitOp;
	logic        bitTrap;
	logic        clkReq;
	logic        extReq;
	logic [3:0]  takeLvl;
	logic        anyReq;
	logic        apbWrite;
	logic        regHit;

	function automatic logic [15:0] mergeBytes(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : mergeBytes

	always_comb begin
		accept  = instrValid && state_r.instrReady;
		privOn  = state_r.ctrl.privCheck && state_r.sr[PRIV_BIT];
		ctlOp   = (instrWord == OP_IDLE) || (instrWord == OP_CLOCK_OFF)
			|| (instrWord == OP_CLOCK_ON) || (instrWord == OP_LOAD_RESTART);
		effAddr = wr12[12:1] + {{4{instrWord[7]}}, instrWord[7:0]};
		bitOp   = (instrWord[15:8] == OP_SET_ONE) || (instrWord[15:8] == OP_SET_ZERO)
			|| (instrWord[15:8] == OP_TEST_BIT);
		bitTrap = privOn && (effAddr >= PRIV_BIT_LIMIT);
		clkReq  = state_r.clkPend && (state_r.sr[MASK_MSB:0] >= CLOCK_LEVEL);
		extReq  = state_r.extReqSync[1] && (state_r.sr[MASK_MSB:0] >= state_r.extLvl2);
		if (extReq && (!clkReq || state_r.extLvl2 < CLOCK_LEVEL)) begin
			takeLvl = state_r.extLvl2;
		end else begin
			takeLvl = CLOCK_LEVEL;
		end
		anyReq   = clkReq || extReq;
		apbWrite = psel && penable && state_r.pready && pwrite && !state_r.pslverr;
		regHit   = (paddr == CTRL_OFS) || (paddr == STAT_OFS) || (paddr == WP_OFS)
			|| (paddr == PC_OFS) || (paddr == SR_OFS);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		state_nxt.offDec     = 1'b0;
		state_nxt.onDec      = 1'b0;
		state_nxt.restartDec = 1'b0;
		state_nxt.errTrap    = 1'b0;
		state_nxt.intTake    = 1'b0;
		state_nxt.bitWrite   = 1'b0;
		state_nxt.pready     = 1'b0;
		state_nxt.pslverr    = 1'b0;
		state_nxt.bitInSync   = {state_r.bitInSync[0], bitIn};
		state_nxt.restartSync = {state_r.restartSync[0], restartReq};
		state_nxt.loadSync    = {state_r.loadSync[0], loadReq};
		state_nxt.extReqSync  = {state_r.extReqSync[0], extIntReq};
		state_nxt.extLvl1     = extIntLevel;
		state_nxt.extLvl2     = state_r.extLvl1;
		// Line clock: tick wins over an interrupt-take clear
		if (state_r.lineClkOn) begin
			if (state_r.lineCnt == CNT_W'(LINE_CYCLES - 1)) begin
				state_nxt.lineCnt = '0;
			end else begin
				state_nxt.lineCnt = state_r.lineCnt + 1'b1;
			end
		end
		case (state_r.fsm)
			S_READY, S_IDLE: begin
				if (state_r.fsm == S_READY && accept) begin
					state_nxt.pc = state_r.pc + PC_STEP;
					if (ctlOp && privOn) begin
						state_nxt.errTrap = 1'b1;
					end else if (instrWord == OP_IDLE) begin
						state_nxt.fsm     = S_IDLE;
						state_nxt.idleSig = 1'b1;
					end else if (instrWord == OP_CLOCK_OFF) begin
						state_nxt.offDec = 1'b1;
						if (!state_r.ctrl.singleChip) begin
							state_nxt.lineClkOn = 1'b0;
							state_nxt.lineCnt   = '0;
						end
					end else if (instrWord == OP_CLOCK_ON) begin
						state_nxt.onDec = 1'b1;
						if (!state_r.ctrl.singleChip) begin
							state_nxt.lineClkOn = 1'b1;
							state_nxt.lineCnt   = '0;
						end
					end else if (instrWord == OP_LOAD_RESTART) begin
						state_nxt.restartDec = 1'b1;
						if (!state_r.ctrl.singleChip) begin
							state_nxt.oldWp    = state_r.wp;
							state_nxt.oldPc    = state_r.pc + PC_STEP;
							state_nxt.oldSr    = state_r.sr;
							state_nxt.fsm      = S_VEC_WP;
							state_nxt.mem.req  = 1'b1;
							state_nxt.mem.we   = 1'b0;
							state_nxt.mem.addr = VEC_WP_ADDR;
						end
					end else if (bitOp && bitTrap) begin
						state_nxt.errTrap = 1'b1;
					end else if (bitOp) begin
						state_nxt.bitAddr = effAddr;
						if (instrWord[15:8] == OP_TEST_BIT) begin
							state_nxt.fsm     = S_TEST;
							state_nxt.testCnt = '0;
						end else begin
							// Status and register twelve stay untouched
							state_nxt.bitWrite = 1'b1;
							state_nxt.bitOut   = (instrWord[15:8] == OP_SET_ONE);
						end
					end
				end else if (anyReq) begin
					state_nxt.fsm      = S_READY;
					state_nxt.idleSig  = 1'b0;
					state_nxt.intTake  = 1'b1;
					state_nxt.intLevel = takeLvl;
					state_nxt.intPc    = state_r.pc;
					state_nxt.sr[MASK_MSB:0] = (takeLvl == MASK_CLEAR) ? MASK_CLEAR
						: takeLvl - 1'b1;
				end else if (state_r.fsm == S_IDLE
						&& (state_r.restartSync[1] || state_r.loadSync[1])) begin
					state_nxt.fsm     = S_READY;
					state_nxt.idleSig = 1'b0;
				end
			end
			S_TEST: begin
				if (state_r.testCnt == TEST_WAIT) begin
					state_nxt.sr[EQ_BIT] = state_r.bitInSync[1];
					state_nxt.fsm        = S_READY;
				end else begin
					state_nxt.testCnt = state_r.testCnt + 1'b1;
				end
			end
			S_VEC_WP: begin
				if (memAck) begin
					state_nxt.wp       = memRdata;
					state_nxt.mem.addr = VEC_PC_ADDR;
					state_nxt.fsm      = S_VEC_PC;
				end
			end
			S_VEC_PC: begin
				if (memAck) begin
					state_nxt.pc        = memRdata;
					state_nxt.mem.we    = 1'b1;
					state_nxt.mem.addr  = state_r.wp + WR13_OFFSET;
					state_nxt.mem.wdata = state_r.oldWp;
					state_nxt.fsm       = S_SAVE13;
				end
			end
			S_SAVE13: begin
				if (memAck) begin
					state_nxt.mem.addr  = state_r.wp + WR14_OFFSET;
					state_nxt.mem.wdata = state_r.oldPc;
					state_nxt.fsm       = S_SAVE14;
				end
			end
			S_SAVE14: begin
				if (memAck) begin
					state_nxt.mem.addr  = state_r.wp + WR15_OFFSET;
					state_nxt.mem.wdata = state_r.oldSr;
					state_nxt.fsm       = S_SAVE15;
				end
			end
			S_SAVE15: begin
				if (memAck) begin
					state_nxt.mem.req        = 1'b0;
					state_nxt.mem.we         = 1'b0;
					state_nxt.sr[MASK_MSB:0] = MASK_CLEAR;
					state_nxt.sr[PRIV_BIT]   = 1'b0;
					if (state_r.ctrl.mapOpt) begin
						state_nxt.sr[MAP_BIT] = 1'b0;
					end
					state_nxt.fsm = S_READY;
				end
			end
			default: begin
				state_nxt.fsm = S_READY;
			end
		endcase
		// Pending clock interrupt: take clears; clock off clears and overrides a tick unless singleChip is set
		if (state_nxt.intTake && takeLvl == CLOCK_LEVEL && clkReq) begin
			state_nxt.clkPend = 1'b0;
		end
		if (state_r.lineClkOn && state_r.lineCnt == CNT_W'(LINE_CYCLES - 1)) begin
			state_nxt.clkPend = 1'b1;
		end
		if (state_nxt.offDec && !state_r.ctrl.singleChip) begin
			state_nxt.clkPend = 1'b0;
		end
		state_nxt.instrReady = (state_nxt.fsm == S_READY) && !state_nxt.intTake;
		// APB: one wait state, write lands at the edge where pready is seen high
		if (psel && penable && !state_r.pready) begin
			state_nxt.pready  = 1'b1;
			state_nxt.pslverr = !regHit;
			state_nxt.prdata  = '0;
			case (paddr)
				CTRL_OFS: state_nxt.prdata[2:0]  = state_r.ctrl;
				STAT_OFS: state_nxt.prdata[5:0]  = {state_r.fsm != S_READY, state_r.mem.req,
					state_r.clkPend, state_r.lineClkOn, state_r.idleSig, state_r.instrReady};
				WP_OFS:   state_nxt.prdata[15:0] = state_r.wp;
				PC_OFS:   state_nxt.prdata[15:0] = state_r.pc;
				SR_OFS:   state_nxt.prdata[15:0] = state_r.sr;
				default:  state_nxt.prdata       = '0;
			endcase
		end
		if (apbWrite) begin
			case (paddr)
				CTRL_OFS: if (pstrb[0]) begin
					state_nxt.ctrl = pwdata[2:0];
				end
				WP_OFS:   state_nxt.wp = mergeBytes(state_r.wp, pwdata, pstrb);
				PC_OFS:   state_nxt.pc = mergeBytes(state_r.pc, pwdata, pstrb);
				SR_OFS:   state_nxt.sr = mergeBytes(state_r.sr, pwdata, pstrb);
				default:  state_nxt.prdata = state_nxt.prdata;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r      <= '0;
			state_r.fsm  <= S_READY;
			state_r.ctrl <= CTRL_RESET;
			state_r.pc   <= CONTEXT_RESET;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata     = state_r.prdata;
	assign pready     = state_r.pready;
	assign pslverr    = state_r.pslverr;
	assign instrReady = state_r.instrReady;
	assign idleSig    = state_r.idleSig;
	assign offDec     = state_r.offDec;
	assign onDec      = state_r.onDec;
	assign restartDec = state_r.restartDec;
	assign errTrap    = state_r.errTrap;
	assign intTake    = state_r.intTake;
	assign intLevel   = state_r.intLevel;
	assign intPc      = state_r.intPc;
	assign bitAddr    = state_r.bitAddr;
	assign bitOut     = state_r.bitOut;
	assign bitWrite   = state_r.bitWrite;
	assign mem        = state_r.mem;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	idle_entry_a: assert property (ce && accept && instrWord == OP_IDLE && !privOn
		|=> idleSig && state_r.fsm == S_IDLE) else $error("idle not entered");
	idle_pc_a: assert property (ce && accept && instrWord == OP_IDLE && !privOn
		|=> state_r.pc == $past(state_r.pc) + PC_STEP) else $error("pc not advanced");
	priv_trap_a: assert property (ce && accept && ctlOp && privOn
		|=> errTrap && !idleSig && !onDec) else $error("privileged op not trapped");
	clock_off_a: assert property (ce && accept && instrWord == OP_CLOCK_OFF && !privOn
		&& !state_r.ctrl.singleChip |=> !state_r.clkPend && !state_r.lineClkOn)
		else $error("clock off left clock running");
	decode_pulse_a: assert property (ce && accept && instrWord == OP_CLOCK_ON && !privOn
		##1 ce && !(accept && instrWord == OP_CLOCK_ON) |-> onDec ##1 !onDec)
		else $error("decode pulse wrong");
	restart_vec_a: assert property (ce && accept && instrWord == OP_LOAD_RESTART
		&& !privOn && !state_r.ctrl.singleChip |=> mem.req && !mem.we
		&& mem.addr == VEC_WP_ADDR) else $error("vector fetch missing");
	set_one_a: assert property (ce && accept && instrWord[15:8] == OP_SET_ONE
		&& !bitTrap |=> bitWrite && bitOut && bitAddr == $past(effAddr))
		else $error("set one wrong");
	bit_trap_a: assert property (ce && accept && bitOp && bitTrap
		|=> errTrap && !bitWrite) else $error("bit access not trapped");
	clock_mask_a: assert property (intTake && intLevel == CLOCK_LEVEL
		|-> state_r.sr[MASK_MSB:0] == CLOCK_LEVEL - 1'b1) else $error("clock mask wrong");
	int_gate_a: assert property ($rose(intTake)
		|-> intLevel <= $past(state_r.sr[MASK_MSB:0])) else $error("masked level taken");

	idle_wake_c: cover property (idleSig ##[1:50] intTake);
	restart_c: cover property (state_r.fsm == S_SAVE15 && memAck);
	test_bit_c: cover property (state_r.fsm == S_TEST ##4 state_r.fsm == S_READY);
	clock_tick_c: cover property (intTake && intLevel == CLOCK_LEVEL);
endmodule : ctl_bit_exec
`default_nettype wire

// File: rtl/ctl_bit_pkg.sv
// Constants, opcodes, register map and shared types for the control and bit-bus executor
`default_nettype none
package ctl_bit_pkg;
	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [15:0] OP_IDLE       = 16'h0340;
	localparam logic [15:0] OP_CLOCK_OFF  = 16'h03C0;
	localparam logic [15:0] OP_CLOCK_ON   = 16'h03A0;
	localparam logic [15:0] OP_LOAD_RESTART = 16'h03E0;
	localparam logic [7:0]  OP_SET_ONE    = 8'h1D;
	localparam logic [7:0]  OP_SET_ZERO   = 8'h1E;
	localparam logic [7:0]  OP_TEST_BIT   = 8'h1F;
	// ----------------------------------------------------------------
	// Status register layout (bit 0 is the least significant)
	// ----------------------------------------------------------------
	localparam int          EQ_BIT        = 13;
	localparam int          PRIV_BIT      = 8;
	localparam int          MAP_BIT       = 7;
	localparam int          MASK_MSB      = 3;
	localparam logic [3:0]  CLOCK_LEVEL   = 4'h5;
	localparam logic [3:0]  MASK_CLEAR    = 4'h0;
	// ----------------------------------------------------------------
	// Context switch and bit bus
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_WP_ADDR   = 16'hFFFC;
	localparam logic [15:0] VEC_PC_ADDR   = 16'hFFFE;
	localparam logic [15:0] WR13_OFFSET   = 16'h001A;
	localparam logic [15:0] WR14_OFFSET   = 16'h001C;
	localparam logic [15:0] WR15_OFFSET   = 16'h001E;
	localparam logic [15:0] PC_STEP       = 16'h0002;
	localparam logic [11:0] PRIV_BIT_LIMIT = 12'hE00;
	localparam logic [1:0]  TEST_WAIT     = 2'h3;
	// ----------------------------------------------------------------
	// Line clock timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          LINE_PERIOD_NS = 8330000;
	localparam int          LINE_CYCLES_DEF = LINE_PERIOD_NS / CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFS      = 8'h00;
	localparam logic [7:0]  STAT_OFS      = 8'h04;
	localparam logic [7:0]  WP_OFS        = 8'h08;
	localparam logic [7:0]  PC_OFS        = 8'h0C;
	localparam logic [7:0]  SR_OFS        = 8'h10;
	localparam logic [2:0]  CTRL_RESET    = 3'h0;
	localparam logic [15:0] CONTEXT_RESET = 16'h0000;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_READY   = 3'b000,
		S_IDLE    = 3'b001,
		S_VEC_WP  = 3'b010,
		S_VEC_PC  = 3'b011,
		S_SAVE13  = 3'b100,
		S_SAVE14  = 3'b101,
		S_SAVE15  = 3'b110,
		S_TEST    = 3'b111
	} exec_state_t;
	typedef struct packed {
		logic singleChip;
		logic mapOpt;
		logic privCheck;
	} ctrl_t;
	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;
endpackage : ctl_bit_pkg
`default_nettype wire
